// File: include/dram_ctl_params.svh
/*
 what this file holds: timing figures, cycle counts and field limits of the 1k x 1 dynamic memory controller.
 what it assumes: a 10 MHz core clock (100 ns period); included by bare name.
*/
`ifndef DRAM_CTL_PARAMS_SVH
`define DRAM_CTL_PARAMS_SVH

// ----------------------------------------
// clock and array geometry
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define ADDR_BITS 10
`define REFRESH_ROWS 32
`define ROW_BITS 5

// ----------------------------------------
// timing figures in ns, refresh period in ms
// ----------------------------------------
`define T_ADDR_SETUP_NS 115
`define T_ADDR_HOLD_NS 20
`define T_PRC_TO_SEL_NS 125
`define T_SEL_TO_PRC_NS 85
`define T_PRC_TO_END_MIN_NS 165
`define T_PRC_TO_END_MAX_NS 500
`define T_PRC_END_TO_DATA_NS 120
`define T_ACCESS_PRC_NS 310
`define T_WRITE_CYCLE_NS 580
`define T_DATA_SETUP_NS 105
`define T_DATA_HOLD_NS 10
`define T_REFRESH_MS 2

// ----------------------------------------
// cycle counts: least times round up, longest round down
// ----------------------------------------
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLOOR_CYC(ns) ((ns) / `CLK_PERIOD_NS)
`define C_ADDR_SETUP `CEIL_CYC(`T_ADDR_SETUP_NS)
`define C_ADDR_HOLD `CEIL_CYC(`T_ADDR_HOLD_NS)
`define C_PRC_TO_SEL `CEIL_CYC(`T_PRC_TO_SEL_NS)
`define C_SEL_TO_PRC `CEIL_CYC(`T_SEL_TO_PRC_NS)
`define C_PRC_TO_END_MIN `CEIL_CYC(`T_PRC_TO_END_MIN_NS)
`define C_PRC_TO_END_MAX `FLOOR_CYC(`T_PRC_TO_END_MAX_NS)
`define C_PRC_END_TO_DATA `CEIL_CYC(`T_PRC_END_TO_DATA_NS)
`define C_WRITE_CYCLE `CEIL_CYC(`T_WRITE_CYCLE_NS)
`define C_DATA_SETUP `CEIL_CYC(`T_DATA_SETUP_NS)
`define C_DATA_HOLD `CEIL_CYC(`T_DATA_HOLD_NS)
// 2 ms sweep in cycles; kept as default of a top parameter
`define C_REFRESH_PERIOD ((`T_REFRESH_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// File: include/dram_ctl_pkg.sv
/*
 what this file holds: types for the dynamic memory controller.
 what it assumes: nothing beyond a SystemVerilog compiler.
*/
package dram_ctl_pkg;

    // user request to the controller
    typedef struct packed {
        logic write;
        logic read_modify;
        logic [9:0] word_address;
        logic data;
    } mem_req_t;

    // pins toward the memory package
    typedef struct packed {
        logic [9:0] word_address;
        logic precharge_strobe;
        logic package_select;
        logic write_strobe;
        logic data_in;
    } mem_pins_t;

    // cycle sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_PRC = 7'h04,
        ST_SEL = 7'h08,
        ST_WSTB = 7'h10,
        ST_SAMPLE = 7'h20,
        ST_REC = 7'h40
    } seq_state_t;

endpackage : dram_ctl_pkg

// File: design/dram_ctl.sv
/*
 what this file holds: host-side controller that runs read, write, read-modify-write and refresh cycles
 on a 1024 x 1 dynamic memory package through its strobes.
 what it assumes: one 10 MHz clock; the memory's data line comes from outside and is OR-tied, so it is
 synchronised here; the user holds a request until it is accepted.
*/
`timescale 1ns/1ps
`include "dram_ctl_params.svh"

module dram_ctl #(
    parameter int REFRESH_PERIOD = `C_REFRESH_PERIOD,
    parameter int PRC_TO_END = `C_PRC_TO_END_MIN + 1
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic req_valid_i,
    input wire dram_ctl_pkg::mem_req_t req_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic rsp_data_o,
    output logic busy_o,
    output logic refresh_active_o,
    output logic [9:0] mem_word_address_o,
    output logic mem_precharge_strobe_o,
    output logic mem_package_select_o,
    output logic mem_write_strobe_o,
    output logic mem_data_in_o,
    input wire logic mem_data_out_i
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // two extra cycles cover the synchroniser on the data line
    localparam int DATA_WAIT = `C_PRC_END_TO_DATA + 2;
    // select ends PRC_TO_END + 1 cycles after precharge rises
    if (PRC_TO_END + 1 < `C_PRC_TO_END_MIN || PRC_TO_END + 1 > `C_PRC_TO_END_MAX) begin : g_bad_end
        $error("PRC_TO_END outside the precharge-to-end window");
    end
    // data goes out as select rises and the strobe must rise inside the select
    if (PRC_TO_END < 1 + `C_DATA_SETUP || PRC_TO_END - 1 < `C_PRC_TO_SEL) begin : g_bad_setup
        $error("PRC_TO_END leaves no room for write data setup");
    end
    if (REFRESH_PERIOD < 4 * `REFRESH_ROWS * `C_WRITE_CYCLE) begin : g_bad_period
        $error("REFRESH_PERIOD too short for a sweep");
    end

    // ----------------------------------------
    // state and storage
    // ----------------------------------------
    dram_ctl_pkg::seq_state_t state;
    dram_ctl_pkg::seq_state_t next_state;
    dram_ctl_pkg::mem_pins_t pins;
    dram_ctl_pkg::mem_req_t cur;
    logic [9:0] cnt;
    logic [9:0] prc_age;
    logic [31:0] ref_timer;
    logic [`ROW_BITS-1:0] ref_row;
    logic [`ROW_BITS:0] ref_left;
    logic ref_cycle;
    logic sync1;
    logic sync2;
    logic sync3;
    logic rd_bit;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire refresh_due = ref_left != '0;
    wire start = state == dram_ctl_pkg::ST_IDLE && (refresh_due || req_valid_i);
    wire take_user = start && !refresh_due;
    wire is_write = !ref_cycle && (cur.write || cur.read_modify);
    wire cnt_done = cnt == 10'h000;
    // strobe rises one cycle before the end, no earlier than the edge where precharge falls
    wire wstb_at = prc_age == 10'(PRC_TO_END - 1);
    wire end_at = prc_age == 10'(PRC_TO_END);
    // the old bit of a read-modify-write shows only after precharge ends, so it waits like a read
    wire rmw_sample = cur.read_modify && !ref_cycle;

    assign req_ready_o = take_user;
    assign busy_o = state != dram_ctl_pkg::ST_IDLE;
    assign refresh_active_o = ref_cycle && busy_o;
    assign mem_word_address_o = pins.word_address;
    assign mem_precharge_strobe_o = pins.precharge_strobe;
    assign mem_package_select_o = pins.package_select;
    assign mem_write_strobe_o = pins.write_strobe;
    assign mem_data_in_o = pins.data_in;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            dram_ctl_pkg::ST_IDLE: begin
                if (start) next_state = dram_ctl_pkg::ST_ADDR;
            end
            // address settles before the precharge so setup to select is met
            dram_ctl_pkg::ST_ADDR: begin
                if (cnt_done) next_state = dram_ctl_pkg::ST_PRC;
            end
            dram_ctl_pkg::ST_PRC: begin
                if (cnt_done) next_state = dram_ctl_pkg::ST_SEL;
            end
            dram_ctl_pkg::ST_SEL: begin
                if (is_write && wstb_at) next_state = dram_ctl_pkg::ST_WSTB;
                else if (!is_write && end_at) next_state = dram_ctl_pkg::ST_SAMPLE;
            end
            dram_ctl_pkg::ST_WSTB: begin
                if (end_at) next_state = rmw_sample ? dram_ctl_pkg::ST_SAMPLE : dram_ctl_pkg::ST_REC;
            end
            dram_ctl_pkg::ST_SAMPLE: begin
                if (cnt_done) next_state = dram_ctl_pkg::ST_REC;
            end
            dram_ctl_pkg::ST_REC: begin
                if (cnt_done) next_state = dram_ctl_pkg::ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // data line synchroniser, change counts when stages 2 and 3 agree
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            rd_bit <= 1'b0;
        end else begin
            sync1 <= mem_data_out_i;
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3) rd_bit <= sync3;
        end
    end

    // ----------------------------------------
    // refresh scheduler: a sweep of 32 row reads every period
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ref_timer <= '0;
            ref_left <= '0;
            ref_row <= '0;
        end else begin
            if (ref_timer == 32'(REFRESH_PERIOD - 1)) begin
                ref_timer <= '0;
                ref_left <= (`ROW_BITS+1)'(`REFRESH_ROWS);
            end else begin
                ref_timer <= ref_timer + 32'h0000_0001;
            end
            // a sweep still running at the period tick restarts; period is checked long enough
            if (start && refresh_due && ref_timer != 32'(REFRESH_PERIOD - 1)) begin
                ref_left <= ref_left - 1'b1;
                ref_row <= ref_row + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // sequencer registers
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state <= dram_ctl_pkg::ST_IDLE;
            cnt <= '0;
            prc_age <= '0;
            cur <= '0;
            ref_cycle <= 1'b0;
        end else begin
            state <= next_state;
            prc_age <= pins.precharge_strobe || state == dram_ctl_pkg::ST_SEL
                || state == dram_ctl_pkg::ST_WSTB ? prc_age + 10'h001 : 10'h000;
            if (!cnt_done) cnt <= cnt - 10'h001;
            if (start) begin
                ref_cycle <= refresh_due;
                // refresh is a plain read of one row, which keeps the cell intact
                cur <= refresh_due ? dram_ctl_pkg::mem_req_t'{write: 1'h0, read_modify: 1'h0,
                    word_address: {5'h00, ref_row}, data: 1'h0} : req_i;
                cnt <= 10'(`C_ADDR_SETUP - `C_PRC_TO_SEL);
            end
            unique case (next_state)
                dram_ctl_pkg::ST_PRC: if (state != dram_ctl_pkg::ST_PRC) cnt <= 10'(`C_PRC_TO_SEL - 1);
                dram_ctl_pkg::ST_SAMPLE: if (state != dram_ctl_pkg::ST_SAMPLE) cnt <= 10'(DATA_WAIT);
                dram_ctl_pkg::ST_REC: begin
                    // cycle time covers both precharge gap and the long write cycle
                    if (state != dram_ctl_pkg::ST_REC)
                        cnt <= is_write ? 10'(`C_WRITE_CYCLE - PRC_TO_END)
                            : 10'(`C_SEL_TO_PRC);
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // pin drive: all registered
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            pins <= '0;
        end else begin
            if (start) pins.word_address <= refresh_due ? {5'h00, ref_row} : req_i.word_address;
            if (next_state == dram_ctl_pkg::ST_PRC) pins.precharge_strobe <= 1'b1;
            // precharge ends one cycle after select rises, while select still stands: the
            // memory latches its output at that fall only when it is selected
            if (state == dram_ctl_pkg::ST_SEL && prc_age == 10'(`C_PRC_TO_SEL))
                pins.precharge_strobe <= 1'h0;
            // write data goes out with the select, two cycles ahead of the strobe end
            if (next_state == dram_ctl_pkg::ST_SEL && state == dram_ctl_pkg::ST_PRC) begin
                pins.package_select <= 1'h1;
                if (is_write) pins.data_in <= cur.data;
            end
            if (next_state == dram_ctl_pkg::ST_WSTB)
                pins.write_strobe <= 1'h1;
            // strobe and select fall together; data and address held past them
            if (end_at && state != dram_ctl_pkg::ST_IDLE) begin
                pins.package_select <= 1'b0;
                pins.write_strobe <= 1'b0;
            end
            if (next_state == dram_ctl_pkg::ST_IDLE && state == dram_ctl_pkg::ST_REC)
                pins.data_in <= 1'b0;
        end
    end

    // ----------------------------------------
    // read answer: sampled after the output delay has passed
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 1'b0;
        end else begin
            rsp_valid_o <= 1'b0;
            if (state == dram_ctl_pkg::ST_SAMPLE && cnt_done && !ref_cycle) begin
                rsp_valid_o <= 1'b1;
                rsp_data_o <= rd_bit;
            end
        end
    end

endmodule : dram_ctl

// File: verification/dram_mem_model.sv
/*
 holds: behavioural 1024 x 1 dynamic memory package seen by the controller.
 assumes: one package on the OR-tied output line, with a load to ground.
*/
`timescale 1ns/1ps
module dram_mem_model #(
    parameter int OUT_DELAY_NS = 120
) (
    input wire logic core_clk_i,
    input wire logic [9:0] word_address_i,
    input wire logic precharge_strobe_i,
    input wire logic package_select_i,
    input wire logic write_strobe_i,
    input wire logic data_in_i,
    output logic data_out_o
);
    // --------
    // storage and output latch
    // --------
    logic cells [0:1023];
    logic held = 1'h0;
    logic drive = 1'h0;
    // known start pattern so refresh reads of untouched rows stay defined
    initial begin
        for (int i = 0; i < 1024; i++) cells[i] = i[0];
    end
    // only a selected write changes a cell; reads leave it alone
    always @(posedge core_clk_i) begin
        if (package_select_i && write_strobe_i) cells[word_address_i] <= data_in_i;
    end
    // old bit latched at end of precharge, shown at the slowest allowed delay
    always @(negedge precharge_strobe_i) begin
        if (package_select_i) begin
            held = cells[word_address_i];
            #(OUT_DELAY_NS) drive = 1'h1;
        end
    end
    // next precharge releases the line; the load pulls it low
    always @(posedge precharge_strobe_i) drive = 1'h0;
    assign data_out_o = drive & held;
endmodule : dram_mem_model

// File: verification/dram_ctl_assertions.sv
/*
 holds: timing checks on the memory pins of the controller.
 assumes: bound to the controller top, 100 ns clock.
*/
`timescale 1ns/1ps
module dram_ctl_assertions (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic refresh_active_o,
    input wire logic [9:0] mem_word_address_o,
    input wire logic mem_precharge_strobe_o,
    input wire logic mem_package_select_o,
    input wire logic mem_write_strobe_o,
    input wire logic mem_data_in_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [3:0] since_prc;
    logic wrote;
    // --------
    // cycles since precharge rose; saturates so a long idle never wraps
    // --------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            since_prc <= 4'hF;
            wrote <= 1'h0;
        end else if ($rose(mem_precharge_strobe_o)) begin
            since_prc <= 4'h1;
            wrote <= 1'h0;
        end else begin
            if (since_prc != 4'hF) since_prc <= since_prc + 4'h1;
            if (mem_write_strobe_o) wrote <= 1'h1;
        end
    end
    property p_addr_setup;
        $rose(mem_package_select_o) |-> $stable(mem_word_address_o) &&
            $past(mem_word_address_o, 2) == mem_word_address_o;
    endproperty
    a_addr_setup: assert property (p_addr_setup) else $error("address not steady around select");
    property p_prc_to_sel;
        $rose(mem_package_select_o) |-> $past(mem_precharge_strobe_o, 2);
    endproperty
    a_prc_to_sel: assert property (p_prc_to_sel) else $error("select too soon after precharge");
    property p_sel_to_prc;
        $rose(mem_precharge_strobe_o) |-> !mem_package_select_o && !$past(mem_package_select_o);
    endproperty
    a_sel_to_prc: assert property (p_sel_to_prc) else $error("precharge too soon after select");
    property p_prc_to_end;
        $rose(mem_precharge_strobe_o) |-> ##[2:5] $fell(mem_package_select_o);
    endproperty
    a_prc_to_end: assert property (p_prc_to_end) else $error("select end out of window");
    property p_write_cycle;
        $rose(mem_precharge_strobe_o) && wrote |-> since_prc >= 4'h6;
    endproperty
    a_write_cycle: assert property (p_write_cycle) else $error("write cycle too short");
    property p_wstb_window;
        $rose(mem_write_strobe_o) |-> since_prc >= 4'h2 && since_prc <= 4'h5;
    endproperty
    a_wstb_window: assert property (p_wstb_window) else $error("write strobe out of window");
    property p_wstb_in_sel;
        mem_write_strobe_o |-> mem_package_select_o;
    endproperty
    a_wstb_in_sel: assert property (p_wstb_in_sel) else $error("write strobe outlives select");
    property p_data_setup;
        $fell(mem_write_strobe_o) |-> $past(mem_data_in_o, 2) == $past(mem_data_in_o);
    endproperty
    a_data_setup: assert property (p_data_setup) else $error("write data set too late");
    property p_data_hold;
        $fell(mem_write_strobe_o) |-> mem_data_in_o == $past(mem_data_in_o);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("write data not held");
    property p_refresh_row;
        mem_package_select_o && refresh_active_o |-> mem_word_address_o[9:5] == 5'h00;
    endproperty
    a_refresh_row: assert property (p_refresh_row) else $error("refresh outside low rows");
    c_write: cover property ($rose(mem_write_strobe_o));
    c_read: cover property ($fell(mem_package_select_o) && !wrote);
    c_refresh: cover property ($rose(refresh_active_o));
endmodule : dram_ctl_assertions
bind dram_ctl dram_ctl_assertions i_dram_ctl_assertions (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .refresh_active_o(refresh_active_o),
    .mem_word_address_o(mem_word_address_o),
    .mem_precharge_strobe_o(mem_precharge_strobe_o),
    .mem_package_select_o(mem_package_select_o),
    .mem_write_strobe_o(mem_write_strobe_o),
    .mem_data_in_o(mem_data_in_o)
);

// File: verification/tb.sv
/*
 holds: self-checking bench for the dynamic memory controller.
 assumes: memory model on the pins, 10 MHz clock, short refresh period.
*/
`timescale 1ns/1ps
module tb;
    localparam int RP = 1000;
    logic core_clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic req_valid_i = 1'h0;
    dram_ctl_pkg::mem_req_t req_i = '0;
    logic req_ready_o, rsp_valid_o, rsp_data_o, busy_o, refresh_active_o;
    logic [9:0] mem_word_address_o;
    logic mem_precharge_strobe_o, mem_package_select_o, mem_write_strobe_o, mem_data_in_o, mem_data_out_i;
    int fail_count = 0;
    int check_count = 0;
    always #50 core_clk_i = ~core_clk_i;
    dram_ctl #(.REFRESH_PERIOD(RP)) i_dram_ctl (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o), .busy_o(busy_o), .refresh_active_o(refresh_active_o),
        .mem_word_address_o(mem_word_address_o), .mem_precharge_strobe_o(mem_precharge_strobe_o),
        .mem_package_select_o(mem_package_select_o), .mem_write_strobe_o(mem_write_strobe_o),
        .mem_data_in_o(mem_data_in_o), .mem_data_out_i(mem_data_out_i));
    dram_mem_model i_dram_mem_model (.core_clk_i(core_clk_i), .word_address_i(mem_word_address_o),
        .precharge_strobe_i(mem_precharge_strobe_o), .package_select_i(mem_package_select_o),
        .write_strobe_i(mem_write_strobe_o), .data_in_i(mem_data_in_o), .data_out_o(mem_data_out_i));
    // --------
    // shared tasks
    // --------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // request held until accepted; ready is judged at the falling edge where it has settled
    task automatic access(input logic w, input logic m, input logic [9:0] a, input logic d, output logic q);
        int n;
        q = 1'hx;
        n = 0;
        @(posedge core_clk_i);
        req_valid_i <= 1'h1;
        req_i <= '{write: w, read_modify: m, word_address: a, data: d};
        do begin
            @(negedge core_clk_i);
            n++;
        end while (req_ready_o !== 1'h1 && n < 2000);
        check("request accepted", req_ready_o, 1'h1);
        @(posedge core_clk_i);
        req_valid_i <= 1'h0;
        n = 0;
        @(negedge core_clk_i);
        check("busy after accept", busy_o, 1'h1);
        if (!w) begin
            do begin
                @(negedge core_clk_i);
                n++;
            end while (rsp_valid_o !== 1'h1 && n < 50);
            check("read answer", rsp_valid_o, 1'h1);
            q = rsp_data_o;
        end
    endtask : access
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // --------
    // scenarios
    // --------
    // back-to-back writes at the address extremes, then each read twice
    task automatic t_write_read;
        logic [9:0] addr [5] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA, 10'h020};
        logic q;
        foreach (addr[i]) access(1'h1, 1'h0, addr[i], i[0], q);
        for (int r = 0; r < 2; r++) begin
            foreach (addr[i]) begin
                access(1'h0, 1'h0, addr[i], 1'h0, q);
                check("read bit", q, i[0]);
            end
        end
    endtask : t_write_read
    // two read-modify-writes in a row each return the bit before them
    task automatic t_rmw;
        logic q;
        access(1'h1, 1'h0, 10'h1C3, 1'h0, q);
        access(1'h0, 1'h1, 10'h1C3, 1'h1, q);
        check("rmw old bit", q, 1'h0);
        access(1'h0, 1'h1, 10'h1C3, 1'h0, q);
        check("rmw old bit", q, 1'h1);
        access(1'h0, 1'h0, 10'h1C3, 1'h0, q);
        check("read after rmw", q, 1'h0);
    endtask : t_rmw
    // idle bus: one full sweep must visit every low row once, inside one period
    task automatic t_refresh;
        logic [31:0] rows;
        logic sel_q;
        logic q;
        int n, got, first;
        rows = '0;
        sel_q = 1'h0;
        n = 0;
        got = 0;
        first = 0;
        while (got < 32 && n < 4 * RP) begin
            @(negedge core_clk_i);
            n++;
            if (mem_package_select_o === 1'h1 && !sel_q && refresh_active_o === 1'h1) begin
                check("refresh upper bits", mem_word_address_o[9:5], 5'h00);
                rows[mem_word_address_o[4:0]] = 1'h1;
                if (got == 0) first = n;
                got++;
            end
            sel_q = mem_package_select_o;
        end
        check("refresh rows", rows, 32'hFFFF_FFFF);
        check("sweep inside period", (n - first) < RP, 1'h1);
        access(1'h0, 1'h0, 10'h3FF, 1'h0, q);
        check("bit after refresh", q, 1'h1);
    endtask : t_refresh
    // main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_b_i <= 1'h1;
        t_write_read();
        t_rmw();
        t_refresh();
        report_and_stop();
    end
    // watchdog: twenty refresh periods is far beyond the whole run
    initial begin
        #(20 * RP * 100);
        fail_count++;
        report_and_stop();
    end
endmodule : tb
